// ==== verilog/bsf_map.svh ====
// Purpose: offsets, field positions and reset values of the unit
// Assumes: byte addresses on a 32-bit apb bus, one word per register
// Notes: status bit order i t h s v n z c, from bit 7 down to bit 0
`ifndef BSF_MAP_SVH
`define BSF_MAP_SVH
`define ADDR_W 12
`define GPR_COUNT 32
`define IO_COUNT 32
`define CMD_OFS 12'h000
`define STATUS_OFS 12'h004
`define STATE_OFS 12'h008
`define GPR_BASE 12'h100
`define IO_BASE 12'h200
`define IDX_LSB 2
`define IDX_MSB 6
`define CMD_OP_LSB 0
`define CMD_RD_LSB 8
`define CMD_RR_LSB 16
`define CMD_BIT_LSB 24
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7
`define STATUS_RST 8'h00
`define BYTE_RST 8'h00
`define STATE_BUSY 0
`define STATE_DONE 1
`endif

// ==== verilog/bsf_pkg.sv ====
// Purpose: types shared by the bit, shift and flag unit
// Assumes: constants come from bsf_map.svh
// Notes: operation codes are the values written to the command field
package bsf_pkg;
`include "bsf_map.svh"
    typedef enum logic [4:0] {
        nop_op, io_bit_set_op, io_bit_clear_op, logical_left_shift_op,
        logical_right_shift_op, rotate_left_carry_op,
        rotate_right_carry_op, arith_right_shift_op, nibble_swap_op,
        generic_flag_set_op, generic_flag_clear_op, bit_to_transfer_op,
        transfer_to_bit_op, carry_set_op, carry_clear_op,
        negative_set_op, negative_clear_op, zero_set_op, zero_clear_op,
        irq_enable_op, irq_disable_op, sign_flag_set_op,
        sign_flag_clear_op, overflow_set_op, overflow_clear_op,
        transfer_flag_set_op, transfer_flag_clear_op,
        half_carry_set_op, half_carry_clear_op, sleep_op,
        watchdog_restart_op, debug_break_op
    } op_t;
    typedef enum logic [0:0] {ph_idle, ph_io_write} phase_t;
    typedef struct packed {
        op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [2:0] bsel;
    } cmd_t;
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] status;
    } alu_out_t;
    typedef struct packed {
        phase_t phase;
        cmd_t cmd;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] status;
        logic [`GPR_COUNT-1:0][7:0] gpr;
        logic [`IO_COUNT-1:0][7:0] io;
        logic sleep_req;
        logic wdt_restart;
        logic debug_break;
        logic op_done;
    } state_t;
endpackage

// ==== verilog/bit_shift_flag_unit.sv ====
// Purpose: bit, shift, rotate and flag instructions of an 8-bit core
// Assumes: one clock pclk at 10 MHz, apb slave, no wait states
// Notes: a write to the command word starts one instruction
//
// What this block does
// - io bit clear zeroes only bit b
// - left shift, zero into bit 0
// - right shift, zero into bit 7
// - rotate left through carry
// - rotate right through carry
// - arithmetic right shift keeps sign bit
// - swap exchanges the two nibbles
// - generic set and clear of flag s
// - register bit b copied to transfer flag
// - transfer flag copied to register bit b
// - carry and negative set and clear
// - zero flag clear, only that flag
// - global interrupt enable set and clear
// - signed-test flag set and clear
// - overflow flag set and clear
// - transfer set, clear, half-carry set
// - sleep takes one cycle, no flags
// - watchdog restart one cycle, no flags
// - break for debug only, no flags
`timescale 1ns/1ps
module bit_shift_flag_unit
    import bsf_pkg::*;
(
    input wire logic pclk, // core clock
    input wire logic presetn, // async reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [`ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error, unmapped address
    output logic [7:0] status_out, // live status register
    output logic sleep_req, // pulse to sleep control
    output logic wdt_restart, // pulse to watchdog
    output logic debug_break, // pulse to debug system
    output logic op_done // pulse when an op retires
);

    state_t cur;
    state_t next_cur;

    // write one bit of a byte
    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] idx,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[idx] = b;
        return r;
    endfunction

    // flags after a shift: z c n v s, others kept
    function automatic logic [7:0] shift_flags(input logic [7:0] status_register,
                                               input logic [7:0] res,
                                               input logic cout);
        logic [7:0] s;
        logic n;
        logic v;
        s = status_register;
        n = res[7];
        v = n ^ cout;
        s[`FLAG_C] = cout;
        s[`FLAG_Z] = (res == `BYTE_RST);
        s[`FLAG_N] = n;
        s[`FLAG_V] = v;
        s[`FLAG_S] = n ^ v;
        return s;
    endfunction

    // shift, rotate and swap datapath
    function automatic alu_out_t shifter(input op_t op,
                                         input logic [7:0] d,
                                         input logic [7:0] status_register);
        alu_out_t o;
        logic c;
        c = status_register[`FLAG_C];
        o.value = d;
        o.status = status_register;
        unique case (op)
            logical_left_shift_op: begin
                o.value = {d[6:0], 1'b0};
                o.status = shift_flags(status_register, o.value, d[7]);
            end
            logical_right_shift_op: begin
                o.value = {1'b0, d[7:1]};
                o.status = shift_flags(status_register, o.value, d[0]);
            end
            rotate_left_carry_op: begin
                o.value = {d[6:0], c};
                o.status = shift_flags(status_register, o.value, d[7]);
            end
            rotate_right_carry_op: begin
                o.value = {c, d[7:1]};
                o.status = shift_flags(status_register, o.value, d[0]);
            end
            arith_right_shift_op: begin
                o.value = {d[7], d[7:1]};
                o.status = shift_flags(status_register, o.value, d[0]);
            end
            nibble_swap_op: begin
                o.value = {d[3:0], d[7:4]};
            end
            default: begin
                o.value = d;
            end
        endcase
        return o;
    endfunction

    // status bit touched by a dedicated flag op, and its new value
    function automatic logic [3:0] flag_target(input op_t op);
        logic [3:0] t;
        t = 4'h0;
        unique case (op)
            carry_set_op: t = {1'b1, `FLAG_C};
            carry_clear_op: t = {1'b0, `FLAG_C};
            negative_set_op: t = {1'b1, `FLAG_N};
            negative_clear_op: t = {1'b0, `FLAG_N};
            zero_set_op: t = {1'b1, `FLAG_Z};
            zero_clear_op: t = {1'b0, `FLAG_Z};
            irq_enable_op: t = {1'b1, `FLAG_I};
            irq_disable_op: t = {1'b0, `FLAG_I};
            sign_flag_set_op: t = {1'b1, `FLAG_S};
            sign_flag_clear_op: t = {1'b0, `FLAG_S};
            overflow_set_op: t = {1'b1, `FLAG_V};
            overflow_clear_op: t = {1'b0, `FLAG_V};
            transfer_flag_set_op: t = {1'b1, `FLAG_T};
            transfer_flag_clear_op: t = {1'b0, `FLAG_T};
            half_carry_set_op: t = {1'b1, `FLAG_H};
            half_carry_clear_op: t = {1'b0, `FLAG_H};
            default: t = 4'h0;
        endcase
        return t;
    endfunction

    // true for the dedicated single-flag ops
    function automatic logic is_flag_op(input op_t op);
        return (op >= carry_set_op) && (op <= half_carry_clear_op);
    endfunction

    // decoded apb request
    logic setup;
    logic access;
    logic wr_ok;
    logic [4:0] word_idx;
    logic hit_cmd;
    logic hit_status;
    logic hit_state;
    logic hit_gpr;
    logic hit_io;
    logic mapped;

    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        wr_ok = access && pwrite && cur.pready && pstrb[0];
        word_idx = paddr[`IDX_MSB:`IDX_LSB];
        hit_cmd = (paddr == `CMD_OFS);
        hit_status = (paddr == `STATUS_OFS);
        hit_state = (paddr == `STATE_OFS);
        hit_gpr = (paddr[`ADDR_W-1:`IDX_MSB+1] ==
                   5'(`GPR_BASE >> (`IDX_MSB + 1))) &&
                  (paddr[1:0] == 2'h0);
        hit_io = (paddr[`ADDR_W-1:`IDX_MSB+1] ==
                  5'(`IO_BASE >> (`IDX_MSB + 1))) &&
                 (paddr[1:0] == 2'h0);
        mapped = hit_cmd || hit_status || hit_state || hit_gpr || hit_io;
    end

    // command word fields; all selects are three or five bits
    cmd_t new_cmd;
    always_comb begin
        new_cmd.op = op_t'(pwdata[`CMD_OP_LSB +: 5]);
        new_cmd.rd = pwdata[`CMD_RD_LSB +: 5];
        new_cmd.rr = pwdata[`CMD_RR_LSB +: 5];
        new_cmd.bsel = pwdata[`CMD_BIT_LSB +: 3];
    end

    // instruction execution and register bus, one state copy
    alu_out_t sh;
    logic [3:0] ft;
    logic start;
    always_comb begin
        next_cur = cur;
        next_cur.sleep_req = 1'b0;
        next_cur.wdt_restart = 1'b0;
        next_cur.debug_break = 1'b0;
        next_cur.op_done = 1'b0;
        start = wr_ok && hit_cmd && (cur.phase == ph_idle);
        sh = shifter(new_cmd.op, cur.gpr[new_cmd.rd], cur.status);
        ft = flag_target(new_cmd.op);

        // apb answer: ready one cycle after setup
        next_cur.pready = setup;
        if (setup) begin
            next_cur.pslverr = !mapped;
            next_cur.prdata = 32'h0000_0000;
            if (!pwrite) begin
                if (hit_status)
                    next_cur.prdata[7:0] = cur.status;
                else if (hit_state) begin
                    next_cur.prdata[`STATE_BUSY] =
                        (cur.phase != ph_idle);
                    next_cur.prdata[`STATE_DONE] = cur.op_done;
                end
                else if (hit_gpr)
                    next_cur.prdata[7:0] = cur.gpr[word_idx];
                else if (hit_io)
                    next_cur.prdata[7:0] = cur.io[word_idx];
                else if (hit_cmd)
                    next_cur.prdata[15:0] = {cur.cmd.bsel,
                        cur.cmd.rr, cur.cmd.rd, 3'h0} & 16'hFFFF;
            end
        end
        else if (access && cur.pready) begin
            next_cur.pslverr = 1'b0;
        end

        // direct software writes of state
        if (wr_ok && hit_status)
            next_cur.status = pwdata[7:0];
        if (wr_ok && hit_gpr)
            next_cur.gpr[word_idx] = pwdata[7:0];
        if (wr_ok && hit_io)
            next_cur.io[word_idx] = pwdata[7:0];

        // second cycle of an io bit op writes back
        if (cur.phase == ph_io_write) begin
            next_cur.io[cur.cmd.rd] = put_bit(cur.io[cur.cmd.rd],
                cur.cmd.bsel,
                cur.cmd.op == io_bit_set_op);
            next_cur.phase = ph_idle;
            next_cur.op_done = 1'b1;
        end

        if (start) begin
            next_cur.cmd = new_cmd;
            next_cur.op_done = 1'b1;
            unique case (new_cmd.op)
                io_bit_set_op, io_bit_clear_op: begin
                    // two cycles; status left alone
                    next_cur.phase = ph_io_write;
                    next_cur.op_done = 1'b0;
                end
                logical_left_shift_op, logical_right_shift_op,
                rotate_left_carry_op, rotate_right_carry_op,
                arith_right_shift_op, nibble_swap_op: begin
                    next_cur.gpr[new_cmd.rd] = sh.value;
                    next_cur.status = sh.status;
                end
                generic_flag_set_op: begin
                    next_cur.status = put_bit(cur.status,
                        new_cmd.bsel, 1'b1);
                end
                generic_flag_clear_op: begin
                    next_cur.status = put_bit(cur.status,
                        new_cmd.bsel, 1'b0);
                end
                bit_to_transfer_op: begin
                    next_cur.status = put_bit(cur.status, `FLAG_T,
                        cur.gpr[new_cmd.rr][new_cmd.bsel]);
                end
                transfer_to_bit_op: begin
                    next_cur.gpr[new_cmd.rd] = put_bit(
                        cur.gpr[new_cmd.rd], new_cmd.bsel,
                        cur.status[`FLAG_T]);
                end
                sleep_op: begin
                    next_cur.sleep_req = 1'b1;
                end
                watchdog_restart_op: begin
                    next_cur.wdt_restart = 1'b1;
                end
                debug_break_op: begin
                    next_cur.debug_break = 1'b1;
                end
                nop_op: begin
                    next_cur.op_done = 1'b1;
                end
                default: begin
                    if (is_flag_op(new_cmd.op))
                        next_cur.status = put_bit(cur.status,
                            ft[2:0], ft[3]);
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.phase <= ph_idle;
            cur.status <= `STATUS_RST;
        end
        else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state flops
    assign pready = cur.pready;
    assign prdata = cur.prdata;
    assign pslverr = cur.pslverr;
    assign status_out = cur.status;
    assign sleep_req = cur.sleep_req;
    assign wdt_restart = cur.wdt_restart;
    assign debug_break = cur.debug_break;
    assign op_done = cur.op_done;

endmodule

// ==== tb/bsf_props.sv ====
// Purpose: port-level checks of the bit, shift and flag unit
// Assumes: one clock, async low reset, apb with no wait states
// Notes: bound to every instance of the unit
`timescale 1ns/1ps
`include "bsf_map.svh"
module bsf_props
    import bsf_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic [`ADDR_W-1:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [3:0] pstrb, // strobes
    input wire logic pready, // ready
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr, // error
    input wire logic [7:0] status_out, // status
    input wire logic sleep_req, // sleep pulse
    input wire logic wdt_restart, // watchdog pulse
    input wire logic debug_break, // break pulse
    input wire logic op_done // retire pulse
);
    // command word taken at this edge
    wire logic cw = psel && penable && pready && pwrite &&
        paddr == `CMD_OFS && pstrb[0];
    wire op_t op = op_t'(pwdata[4:0]);
    wire logic [7:0] bm = 8'h01 << pwdata[26:24];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_flag_set_bit: assert property (
        cw && op == generic_flag_set_op
        |=> status_out == ($past(status_out) | $past(bm)))
        else $error("flag set wrong");
    chk_flag_clear_bit: assert property (
        cw && op == generic_flag_clear_op
        |=> status_out == ($past(status_out) & ~$past(bm)))
        else $error("flag clear wrong");
    chk_carry_set_only: assert property (
        cw && op == carry_set_op
        |=> status_out == ($past(status_out) | 8'h01))
        else $error("carry set wrong");
    chk_zero_clear_only: assert property (
        cw && op == zero_clear_op
        |=> status_out == ($past(status_out) & 8'hFD))
        else $error("zero clear wrong");
    chk_irq_enable_bit: assert property (
        cw && op == irq_enable_op
        |=> status_out[7] && status_out[6:0] == $past(status_out[6:0]))
        else $error("irq enable wrong");
    chk_swap_keeps_flags: assert property (
        cw && op == nibble_swap_op |=> $stable(status_out))
        else $error("swap changed flags");
    chk_store_only_t: assert property (
        cw && op == bit_to_transfer_op
        |=> ((status_out ^ $past(status_out)) & 8'hBF) == 8'h00)
        else $error("store changed other flags");
    chk_io_clear_timing: assert property (
        cw && op == io_bit_clear_op |=> !op_done && $stable(status_out)
        ##1 op_done && $stable(status_out))
        else $error("io clear timing wrong");
    chk_sleep_pulse: assert property (
        cw && op == sleep_op |=> sleep_req && op_done &&
        $stable(status_out) ##1 !sleep_req)
        else $error("sleep pulse wrong");
    chk_wdr_pulse: assert property (
        cw && op == watchdog_restart_op |=> wdt_restart && op_done &&
        $stable(status_out) ##1 !wdt_restart)
        else $error("watchdog pulse wrong");
    chk_break_flags: assert property (
        cw && op == debug_break_op
        |=> debug_break && $stable(status_out))
        else $error("break changed flags");
    chk_flag_one_cycle: assert property (
        cw && op inside {[carry_set_op:half_carry_clear_op]} |=> op_done)
        else $error("flag op not one cycle");
    // main scenarios reached
    cover property (sleep_req);
    cover property (pready && pslverr);
    cover property (cw && op == io_bit_clear_op);
endmodule
bind bit_shift_flag_unit bsf_props bsf_props_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .status_out(status_out),
    .sleep_req(sleep_req), .wdt_restart(wdt_restart),
    .debug_break(debug_break), .op_done(op_done));

// ==== tb/bit_shift_flag_unit_bench.sv ====
// Purpose: self-checking bench of the bit, shift and flag unit
// Assumes: apb master here, reads checked from a queue of notes
// Notes: random data from a fixed seed
`timescale 1ns/1ps
`include "bsf_map.svh"
module bit_shift_flag_unit_bench
    import bsf_pkg::*;
();
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, sleep_req, wdt_restart, debug_break, op_done;
    logic [31:0] prdata;
    logic [7:0] status_out;
    int n_errors = 0, checked = 0;
    logic [32:0] expq [$];
    localparam logic [2:0] fl [8] = '{`FLAG_C, `FLAG_N, `FLAG_Z,
        `FLAG_I, `FLAG_S, `FLAG_V, `FLAG_T, `FLAG_H};
    bit_shift_flag_unit bit_shift_flag_unit_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .status_out(status_out),
        .sleep_req(sleep_req), .wdt_restart(wdt_restart),
        .debug_break(debug_break), .op_done(op_done));
    // 100 ns clock
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // each read answer against the oldest note
    always @(posedge pclk) begin
        if ((psel && penable && pready && !pwrite) === 1'b1) begin
            cmp({pslverr, prdata}, expq.pop_front());
        end
    end
    // one apb transfer, held until ready
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h000000, d});
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e,
        input logic err = 1'b0);
        expq.push_back({err, 24'h000000, e});
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic op(input op_t o, input logic [4:0] d,
        input logic [4:0] r, input logic [2:0] b);
        xfer(1'b1, `CMD_OFS, {5'h00, b, 3'h0, r, 3'h0, d, 3'h0, o});
    endtask
    function automatic logic [11:0] gpr(input logic [4:0] n);
        return `GPR_BASE + {5'h00, n, 2'h0};
    endfunction
    function automatic logic [11:0] io(input logic [4:0] n);
        return `IO_BASE + {5'h00, n, 2'h0};
    endfunction
    // shift result and new status
    function automatic logic [15:0] model(input op_t o,
        input logic [7:0] d, input logic [7:0] s);
        logic [7:0] r;
        logic c;
        logic n;
        logic v;
        c = d[0];
        case (o)
            logical_left_shift_op: {c, r} = {d, 1'b0};
            logical_right_shift_op: r = {1'b0, d[7:1]};
            rotate_left_carry_op: {c, r} = {d, s[0]};
            rotate_right_carry_op: r = {s[0], d[7:1]};
            arith_right_shift_op: r = {d[7], d[7:1]};
            default: return {d[3:0], d[7:4], s};
        endcase
        n = r[7];
        v = n ^ c;
        return {r, s[7:5], n ^ v, v, n, r == 8'h00, c};
    endfunction
    // main sequence
    initial begin
        logic [7:0] v, s, w;
        logic [4:0] n;
        logic [2:0] b;
        logic [15:0] m;
        void'($urandom(32'h7B8A));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`STATUS_OFS, `STATUS_RST);
        rd_chk(12'h00C, 8'h00, 1'b1);
        $display("reset and map test done");
        for (int i = 3; i <= 8; i++) begin
            repeat (4) begin
                v = $urandom;
                s = $urandom;
                n = $urandom;
                wr(gpr(n), v);
                wr(`STATUS_OFS, s);
                op(op_t'(i), n, 5'h00, 3'h0);
                m = model(op_t'(i), v, s);
                rd_chk(gpr(n), m[15:8]);
                rd_chk(`STATUS_OFS, m[7:0]);
            end
        end
        $display("shift test done");
        for (int i = 9; i <= 28; i++) begin
            if (i == 11 || i == 12) continue;
            for (int j = 0; j < 8; j++) begin
                s = $urandom;
                b = (i < 13) ? 3'(j) : fl[(i - 13) / 2];
                wr(`STATUS_OFS, s);
                op(op_t'(i), 5'h00, 5'h00, b);
                s[b] = i[0];
                rd_chk(`STATUS_OFS, s);
            end
        end
        $display("flag test done");
        repeat (8) begin
            v = $urandom;
            w = $urandom;
            s = $urandom;
            n = $urandom;
            b = $urandom;
            wr(gpr(n), v);
            wr(`STATUS_OFS, s);
            op(bit_to_transfer_op, 5'h00, n, b);
            s[6] = v[b];
            rd_chk(`STATUS_OFS, s);
            wr(gpr(n), w);
            op(transfer_to_bit_op, n, 5'h00, b);
            w[b] = s[6];
            rd_chk(gpr(n), w);
            wr(io(n), v);
            op(io_bit_clear_op, n, 5'h00, b);
            v[b] = 1'b0;
            rd_chk(io(n), v);
            rd_chk(`STATUS_OFS, s);
        end
        $display("bit transfer test done");
        for (int i = 29; i <= 31; i++) begin
            s = $urandom;
            wr(`STATUS_OFS, s);
            op(op_t'(i), 5'h00, 5'h00, 3'h0);
            rd_chk(`STATUS_OFS, s);
            cmp({25'h0000000, status_out}, {25'h0000000, s});
        end
        $display("control test done");
        @(posedge pclk);
        complete_run();
    end
endmodule
